// File: hdl/simd_alu_pkg.sv
package simd_alu_pkg;

    // ********************************
    // Operation select
    // ********************************
    typedef enum logic [4:0] {
        OP_NONE                          = 5'h00,
        OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE = 5'h01,
        OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE = 5'h02,
        OP_UNSIGNED_SAT_DUAL_HALF_ADD    = 5'h03,
        OP_UNSIGNED_SAT_QUAD_BYTE_ADD    = 5'h04,
        OP_UNSIGNED_SAT_DUAL_HALF_SUB    = 5'h05,
        OP_UNSIGNED_SAT_QUAD_BYTE_SUB    = 5'h06,
        OP_PACK_BOTTOM_TOP               = 5'h07,
        OP_PACK_TOP_BOTTOM               = 5'h08,
        OP_SIGN_EXTEND_BYTE              = 5'h09,
        OP_SIGN_EXTEND_HALF              = 5'h0A,
        OP_SIGN_EXTEND_DUAL_BYTE         = 5'h0B,
        OP_ZERO_EXTEND_BYTE              = 5'h0C,
        OP_ZERO_EXTEND_HALF              = 5'h0D,
        OP_ZERO_EXTEND_DUAL_BYTE         = 5'h0E,
        OP_SIGN_EXTEND_BYTE_ADD          = 5'h0F,
        OP_SIGN_EXTEND_HALF_ADD          = 5'h10,
        OP_SIGN_EXTEND_DUAL_BYTE_ADD     = 5'h11,
        OP_ZERO_EXTEND_BYTE_ADD          = 5'h12,
        OP_ZERO_EXTEND_HALF_ADD          = 5'h13,
        OP_ZERO_EXTEND_DUAL_BYTE_ADD     = 5'h14
    } alu_op_e;

    // ********************************
    // Field layout and constants
    // ********************************
    localparam int          WORD_W       = 32;
    localparam int          HALF_W       = 16;
    localparam int          BYTE_W       = 8;
    localparam int          HALF_HI_LSB  = 16;
    localparam int          BYTE2_LSB    = 16;
    localparam int          RES_DEST_W   = 4;
    localparam logic [4:0]  ASR_FULL_ENC = 5'h00;
    localparam logic [1:0]  ROT_NONE     = 2'h0;
    localparam logic [31:0] RESULT_RST   = 32'h0000_0000;

    // ********************************
    // Request and result carriers
    // ********************************
    typedef struct packed {
        logic                  valid;
        alu_op_e               op;
        logic [WORD_W-1:0]     first_operand_reg;
        logic [WORD_W-1:0]     second_operand_reg;
        logic [4:0]            shift_amount;
        logic [1:0]            rotate_sel;
        logic [RES_DEST_W-1:0] dest;
    } alu_req_s;

    typedef struct packed {
        logic                  valid;
        logic [WORD_W-1:0]     value;
        logic [RES_DEST_W-1:0] dest;
    } alu_res_s;

endpackage

// File: hdl/simd_saturate_pack_extend_alu.sv
`timescale 1ns/1ps
// Contract
// - Add-sub-exchange: low1+high2 saturated into top half
// - Add-sub-exchange: high1-low2 clamped into bottom half
// - Sub-add-exchange: high1-low2 clamped into top half
// - Sub-add-exchange: low1+high2 saturated into bottom half
// - Dual halfword add, each lane clamped
// - Quad byte add, each lane clamped
// - Dual halfword subtract, negatives become zero
// - Quad byte subtract, each lane clamped
// - No operation changes condition flags
// - Pack bottom-top: low1, top of shifted-left op2
// - Pack top-bottom: high1, low of arith-shifted op2
// - Left shift 0..31; right shift code zero means 32
// - Extends rotate second operand by 0/8/16/24
// - Byte extend takes bits 7..0 to 32
// - Half extend takes bits 15..0 to 32
// - Dual byte extend bits 7..0, 23..16
// - Extend-add adds to word or halfwords
module simd_saturate_pack_extend_alu
    import simd_alu_pkg::*;
(
    // Clock and reset
    input  wire logic     ref_clk,
    input  wire logic     sys_rst,
    // Issue side
    input  wire alu_req_s req,
    // Write-back side
    output alu_res_s      res,
    output logic          flags_write,
    output logic          sticky_sat_write
);

    // ********************************
    // Operand fields
    // ********************************
    logic [WORD_W-1:0] op1;
    logic [WORD_W-1:0] op2;
    logic [HALF_W-1:0] op1_lo;
    logic [HALF_W-1:0] op1_hi;
    logic [HALF_W-1:0] op2_lo;
    logic [HALF_W-1:0] op2_hi;

    assign op1    = req.first_operand_reg;
    assign op2    = req.second_operand_reg;
    assign op1_lo = op1[HALF_W-1:0];
    assign op1_hi = op1[HALF_HI_LSB +: HALF_W];
    assign op2_lo = op2[HALF_W-1:0];
    assign op2_hi = op2[HALF_HI_LSB +: HALF_W];

    // ********************************
    // Lane arithmetic
    // ********************************
    logic [HALF_W-1:0] cross_sum;
    logic [HALF_W-1:0] cross_diff;
    logic [WORD_W-1:0] dual_add;
    logic [WORD_W-1:0] dual_sub;
    logic [WORD_W-1:0] quad_add;
    logic [WORD_W-1:0] quad_sub;

    sat_lane #(
        .W   (HALF_W),
        .SUB (1'b0)
    ) u_cross_sum (
        .a (op1_lo),
        .b (op2_hi),
        .y (cross_sum)
    );

    sat_lane #(
        .W   (HALF_W),
        .SUB (1'b1)
    ) u_cross_diff (
        .a (op1_hi),
        .b (op2_lo),
        .y (cross_diff)
    );

    sat_lane #(
        .W   (HALF_W),
        .SUB (1'b0)
    ) u_add_hi (
        .a (op1_hi),
        .b (op2_hi),
        .y (dual_add[HALF_HI_LSB +: HALF_W])
    );

    sat_lane #(
        .W   (HALF_W),
        .SUB (1'b0)
    ) u_add_lo (
        .a (op1_lo),
        .b (op2_lo),
        .y (dual_add[HALF_W-1:0])
    );

    sat_lane #(
        .W   (HALF_W),
        .SUB (1'b1)
    ) u_sub_hi (
        .a (op1_hi),
        .b (op2_hi),
        .y (dual_sub[HALF_HI_LSB +: HALF_W])
    );

    sat_lane #(
        .W   (HALF_W),
        .SUB (1'b1)
    ) u_sub_lo (
        .a (op1_lo),
        .b (op2_lo),
        .y (dual_sub[HALF_W-1:0])
    );

    // Byte lanes kept independent, no carry chain between them
    genvar g;
    generate
        for (g = 0; g < WORD_W / BYTE_W; g++) begin : g_byte
            sat_lane #(
                .W   (BYTE_W),
                .SUB (1'b0)
            ) u_add (
                .a (op1[g*BYTE_W +: BYTE_W]),
                .b (op2[g*BYTE_W +: BYTE_W]),
                .y (quad_add[g*BYTE_W +: BYTE_W])
            );

            sat_lane #(
                .W   (BYTE_W),
                .SUB (1'b1)
            ) u_sub (
                .a (op1[g*BYTE_W +: BYTE_W]),
                .b (op2[g*BYTE_W +: BYTE_W]),
                .y (quad_sub[g*BYTE_W +: BYTE_W])
            );
        end
    endgenerate

    // ********************************
    // Packing shifts
    // ********************************
    logic [WORD_W-1:0] shl_val;
    logic [WORD_W-1:0] asr_val;

    // Zero amount passes through unshifted
    assign shl_val = op2 << req.shift_amount;

    // Encoded zero stands for 32; result is all sign bits, same as 31
    always_comb begin
        if (req.shift_amount == ASR_FULL_ENC) begin
            asr_val = {WORD_W{op2[WORD_W-1]}};
        end else begin
            asr_val = $signed(op2) >>> req.shift_amount;
        end
    end

    // ********************************
    // Rotate and extend
    // ********************************
    logic [WORD_W-1:0] rot_val;
    logic [WORD_W-1:0] rot_dbl;
    logic [5:0]        rot_bits;
    logic [WORD_W-1:0] sx_byte;
    logic [WORD_W-1:0] zx_byte;
    logic [WORD_W-1:0] sx_half;
    logic [WORD_W-1:0] zx_half;
    logic [WORD_W-1:0] sx_dual;
    logic [WORD_W-1:0] zx_dual;
    logic [7:0]        rb0;
    logic [7:0]        rb2;

    // Select 0,8,16,24 from two-bit field; decoder sends ROT_NONE when absent
    assign rot_bits = {1'b0, req.rotate_sel, 3'b000};
    assign rot_dbl  = op2 >> rot_bits;
    assign rot_val  = rot_dbl | (op2 << (6'd32 - rot_bits));

    assign rb0     = rot_val[BYTE_W-1:0];
    assign rb2     = rot_val[BYTE2_LSB +: BYTE_W];
    assign sx_byte = {{(WORD_W-BYTE_W){rb0[BYTE_W-1]}}, rb0};
    assign zx_byte = {{(WORD_W-BYTE_W){1'b0}}, rb0};
    assign sx_half = {{HALF_W{rot_val[HALF_W-1]}}, rot_val[HALF_W-1:0]};
    assign zx_half = {{HALF_W{1'b0}}, rot_val[HALF_W-1:0]};
    assign sx_dual = {{BYTE_W{rb2[BYTE_W-1]}}, rb2, {BYTE_W{rb0[BYTE_W-1]}}, rb0};
    assign zx_dual = {{BYTE_W{1'b0}}, rb2, {BYTE_W{1'b0}}, rb0};

    // Halfword-wise add: lower carry deliberately dropped
    function automatic logic [WORD_W-1:0] add_dual(input logic [WORD_W-1:0] a,
                                                  input logic [WORD_W-1:0] b);
        logic [HALF_W-1:0] lo;
        logic [HALF_W-1:0] hi;
        lo = a[HALF_W-1:0] + b[HALF_W-1:0];
        hi = a[HALF_HI_LSB +: HALF_W] + b[HALF_HI_LSB +: HALF_W];
        add_dual = {hi, lo};
    endfunction

    // ********************************
    // Result select
    // ********************************
    logic [WORD_W-1:0] result_d;

    always_comb begin
        unique case (req.op)
            OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE: result_d = {cross_sum, cross_diff};
            OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE: result_d = {cross_diff, cross_sum};
            OP_UNSIGNED_SAT_DUAL_HALF_ADD:    result_d = dual_add;
            OP_UNSIGNED_SAT_QUAD_BYTE_ADD:    result_d = quad_add;
            OP_UNSIGNED_SAT_DUAL_HALF_SUB:    result_d = dual_sub;
            OP_UNSIGNED_SAT_QUAD_BYTE_SUB:    result_d = quad_sub;
            OP_PACK_BOTTOM_TOP:
                result_d = {shl_val[HALF_HI_LSB +: HALF_W], op1_lo};
            OP_PACK_TOP_BOTTOM:
                result_d = {op1_hi, asr_val[HALF_W-1:0]};
            OP_SIGN_EXTEND_BYTE:              result_d = sx_byte;
            OP_SIGN_EXTEND_HALF:              result_d = sx_half;
            OP_SIGN_EXTEND_DUAL_BYTE:         result_d = sx_dual;
            OP_ZERO_EXTEND_BYTE:              result_d = zx_byte;
            OP_ZERO_EXTEND_HALF:              result_d = zx_half;
            OP_ZERO_EXTEND_DUAL_BYTE:         result_d = zx_dual;
            OP_SIGN_EXTEND_BYTE_ADD:          result_d = op1 + sx_byte;
            OP_SIGN_EXTEND_HALF_ADD:          result_d = op1 + sx_half;
            OP_SIGN_EXTEND_DUAL_BYTE_ADD:     result_d = add_dual(op1, sx_dual);
            OP_ZERO_EXTEND_BYTE_ADD:          result_d = op1 + zx_byte;
            OP_ZERO_EXTEND_HALF_ADD:          result_d = op1 + zx_half;
            OP_ZERO_EXTEND_DUAL_BYTE_ADD:     result_d = add_dual(op1, zx_dual);
            default:                          result_d = RESULT_RST;
        endcase
    end

    // ********************************
    // Result register
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res.valid <= 1'b0;
        end else begin
            res.valid <= req.valid && (req.op != OP_NONE);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res.value <= RESULT_RST;
        end else if (req.valid) begin
            res.value <= result_d;
        end
    end

    // Destination tag follows the value it labels
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res.dest <= '0;
        end else if (req.valid) begin
            res.dest <= req.dest;
        end
    end

    // Neither condition flags nor sticky saturation are ever written
    assign flags_write      = 1'b0;
    assign sticky_sat_write = 1'b0;

endmodule

// ********************************
// Saturating lane
// ********************************
module sat_lane
#(
    parameter int W   = 16,
    parameter bit SUB = 1'b0
)
(
    // Lane operands
    input  logic [W-1:0] a,
    input  logic [W-1:0] b,
    // Clamped lane result
    output logic [W-1:0] y
);

    logic [W:0] wide;

    // Guard bit shows carry out or borrow before clamping
    assign wide = SUB ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});

    always_comb begin
        if (!wide[W]) begin
            y = wide[W-1:0];
        end else if (SUB) begin
            y = '0;
        end else begin
            y = '1;
        end
    end

endmodule

// File: tb/simd_alu_checker_assertions.sv
`timescale 1ns/1ps
module simd_alu_checker
    import simd_alu_pkg::*;
(
    // Watched ports
    input wire logic     ref_clk,
    input wire logic     sys_rst,
    input wire alu_req_s req,
    input wire alu_res_s res,
    input wire logic     flags_write,
    input wire logic     sticky_sat_write
);
    logic [31:0] a_q;
    logic [31:0] b_q;
    logic [3:0]  d_q;
    always_ff @(posedge ref_clk) begin
        a_q <= req.first_operand_reg;
        b_q <= req.second_operand_reg;
        d_q <= req.dest;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_go(alu_op_e o);
        req.valid && req.op == o;
    endsequence
    property p_answer; req.valid && req.op != OP_NONE |=> res.valid && res.dest == d_q; endproperty
    a_answer: assert property (p_answer) else $error("result late or misrouted");
    property p_flags; !flags_write && !sticky_sat_write; endproperty
    a_flags: assert property (p_flags) else $error("flag write seen");
    property p_asx; s_go(OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE) |=>
        res.value[31:16] >= a_q[15:0] && res.value[15:0] <= a_q[31:16]; endproperty
    a_asx: assert property (p_asx) else $error("add-sub exchange lane wrong");
    property p_sax; s_go(OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE) |=>
        res.value[31:16] <= a_q[31:16] && res.value[15:0] >= a_q[15:0]; endproperty
    a_sax: assert property (p_sax) else $error("sub-add exchange lane wrong");
    property p_hadd; s_go(OP_UNSIGNED_SAT_DUAL_HALF_ADD) |=>
        res.value[31:16] >= b_q[31:16] && res.value[15:0] >= a_q[15:0]; endproperty
    a_hadd: assert property (p_hadd) else $error("halfword add wrapped");
    property p_bsub; s_go(OP_UNSIGNED_SAT_QUAD_BYTE_SUB) |=>
        res.value[7:0] <= a_q[7:0] && res.value[31:24] <= a_q[31:24]; endproperty
    a_bsub: assert property (p_bsub) else $error("byte subtract wrapped");
    property p_pack; s_go(OP_PACK_BOTTOM_TOP) |=> res.value[15:0] == a_q[15:0]; endproperty
    a_pack: assert property (p_pack) else $error("pack bottom half wrong");
    property p_zext; s_go(OP_ZERO_EXTEND_BYTE) ##0 req.rotate_sel == ROT_NONE |=>
        res.value == {24'h0, b_q[7:0]}; endproperty
    a_zext: assert property (p_zext) else $error("byte zero extend wrong");
    property p_sexth; s_go(OP_SIGN_EXTEND_HALF) |=> res.value[31:16] == {16{res.value[15]}};
    endproperty
    a_sexth: assert property (p_sexth) else $error("half sign extend wrong");
endmodule
bind simd_saturate_pack_extend_alu simd_alu_checker u_chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .req(req), .res(res), .flags_write(flags_write),
    .sticky_sat_write(sticky_sat_write));

// File: tb/simd_issue_model.sv
`timescale 1ns/1ps
module simd_issue_model
    import simd_alu_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Request to the block
    output alu_req_s req
);
    initial req = '0;
    task automatic issue(input alu_req_s r);
        @(negedge ref_clk);
        // Stack and program counter slots are never targeted
        if (r.dest inside {4'hD, 4'hF}) r.dest[2] = 1'b0;
        req = r;
    endtask
    // Released lines show junk, not the last value
    task automatic idle();
        alu_req_s junk;
        @(negedge ref_clk);
        junk       = ~req;
        junk.valid = 1'b0;
        junk.op    = OP_NONE;
        req        = junk;
    endtask
endmodule

// File: tb/simd_saturate_pack_extend_alu_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin fail_count++; \
    $display("unexpected %s: expected %h seen %h", n, e, s); end end
module simd_saturate_pack_extend_alu_bench
    import simd_alu_pkg::*;
;
    logic        ref_clk;
    logic        sys_rst = 1'b1;
    alu_req_s    req;
    alu_res_s    res;
    logic        flags_write;
    logic        sticky_sat_write;
    logic        exp_v = 1'b0;
    logic [31:0] exp_val;
    logic [3:0]  exp_dest;
    logic [15:0] lfsr = 16'h5D0E;
    int          fail_count, tests_run, cycles;
    alu_req_s    r;
    logic [31:0] cv [4] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'h8001_7F80, 32'h7FFF_0001};
    logic [4:0]  sv [4] = '{5'h00, 5'h01, 5'h1F, 5'h10};

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    simd_issue_model u_iss (.ref_clk(ref_clk), .req(req));
    simd_saturate_pack_extend_alu u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req),
        .res(res), .flags_write(flags_write), .sticky_sat_write(sticky_sat_write));

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    // Extra top bit catches carry and borrow per lane
    function automatic logic [15:0] sat(logic [15:0] a, logic [15:0] b, int w, bit sb);
        logic [16:0] t;
        t = sb ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
        return (t >> w) != 0 ? (sb ? 16'h0 : 16'((1 << w) - 1)) : t[15:0];
    endfunction
    function automatic logic [31:0] model(alu_req_s q);
        logic [31:0] a, b, o, x, v;
        alu_op_e     op;
        a = q.first_operand_reg;
        b = q.second_operand_reg;
        o = (b >> (8 * q.rotate_sel)) | (b << (32 - 8 * q.rotate_sel));
        op = q.op >= OP_SIGN_EXTEND_BYTE_ADD ? alu_op_e'(q.op - 5'h06) : q.op;
        case (op)
            OP_UNSIGNED_SAT_ADD_SUB_EXCHANGE: v = {sat(a[15:0], b[31:16], 16, 0),
                sat(a[31:16], b[15:0], 16, 1)};
            OP_UNSIGNED_SAT_SUB_ADD_EXCHANGE: v = {sat(a[31:16], b[15:0], 16, 1),
                sat(a[15:0], b[31:16], 16, 0)};
            OP_UNSIGNED_SAT_DUAL_HALF_ADD, OP_UNSIGNED_SAT_DUAL_HALF_SUB: v = {
                sat(a[31:16], b[31:16], 16, op[2]), sat(a[15:0], b[15:0], 16, op[2])};
            OP_UNSIGNED_SAT_QUAD_BYTE_ADD, OP_UNSIGNED_SAT_QUAD_BYTE_SUB: begin
                for (int i = 0; i < 4; i++)
                    v[8*i+:8] = 8'(sat(16'(a[8*i+:8]), 16'(b[8*i+:8]), 8, op[1]));
            end
            OP_PACK_BOTTOM_TOP: begin x = b << q.shift_amount; v = {x[31:16], a[15:0]}; end
            OP_PACK_TOP_BOTTOM: begin
                x = $signed(b) >>> (q.shift_amount == 5'h00 ? 32 : q.shift_amount);
                v = {a[31:16], x[15:0]};
            end
            OP_SIGN_EXTEND_BYTE:      v = {{24{o[7]}}, o[7:0]};
            OP_SIGN_EXTEND_HALF:      v = {{16{o[15]}}, o[15:0]};
            OP_SIGN_EXTEND_DUAL_BYTE: v = {{8{o[23]}}, o[23:16], {8{o[7]}}, o[7:0]};
            OP_ZERO_EXTEND_BYTE:      v = {24'h0, o[7:0]};
            OP_ZERO_EXTEND_HALF:      v = {16'h0, o[15:0]};
            OP_ZERO_EXTEND_DUAL_BYTE: v = {8'h0, o[23:16], 8'h0, o[7:0]};
            default:                  v = 32'h0;
        endcase
        if (q.op >= OP_SIGN_EXTEND_BYTE_ADD)
            v = op inside {OP_SIGN_EXTEND_DUAL_BYTE, OP_ZERO_EXTEND_DUAL_BYTE} ?
                {a[31:16] + v[31:16], a[15:0] + v[15:0]} : a + v;
        return v;
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        exp_v <= req.valid && req.op != OP_NONE && !sys_rst;
        exp_val <= model(req);
        exp_dest <= req.dest;
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    always @(negedge ref_clk) if (!sys_rst) begin
        `CHK("flags", 2'b00, {flags_write, sticky_sat_write})
        `CHK("valid", exp_v, res.valid)
        if (exp_v) `CHK("value", {exp_dest, exp_val}, {res.dest, res.value})
    end

    initial begin
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'b0;
        for (int o = 1; o <= 20; o++)
            for (int k = 0; k < 4; k++)
                u_iss.issue('{1'b1, alu_op_e'(o), cv[k], cv[3-k], sv[k], 2'(k), 4'(o)});
        u_iss.idle();
        $display("corner test done");
        repeat (300) begin
            r = '{1'b1, alu_op_e'(5'(1 + rnd() % 20)), {rnd(), rnd()}, {rnd(), rnd()},
                  5'(rnd()), 2'(rnd()), 4'(rnd())};
            u_iss.issue(r);
            if (rnd() % 4 == 0) u_iss.idle();
        end
        u_iss.idle();
        $display("random test done");
        u_iss.issue('{1'b1, OP_NONE, cv[0], cv[0], 5'h00, 2'h0, 4'h1});
        @(posedge ref_clk);
        #1 `CHK("none", {1'b0, RESULT_RST}, {res.valid, res.value})
        u_iss.idle();
        sys_rst = 1'b1;
        u_iss.issue(r);
        @(posedge ref_clk);
        #1 `CHK("reset", {1'b0, RESULT_RST}, {res.valid, res.value})
        u_iss.idle();
        sys_rst = 1'b0;
        u_iss.issue(r);
        u_iss.idle();
        repeat (3) @(negedge ref_clk);
        $display("reset test done");
        stop_test();
    end
endmodule
